// ===== bench/pbp_boost_pwm_tb.sv
// Self-checking bench for the push-pull boost waveform block
`timescale 1ns/1ps
module pbp_boost_pwm_tb;
  import pbp_pkg::*;
  typedef struct {int per; int pp1; int pp2; int la1; int lb1; bit legs; bit flags;} pbp_note_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] build_sel = 2'h1;
  logic acm = 1'b0;
  logic [DUTY_W-1:0] op_d = 10'h1C2, vl_d = 10'h1C2, cl_d = 10'h1C2;
  logic [DT_W-1:0] dta = 8'h00, dtb = 8'h00;
  logic [DAC_W-1:0] hv_code = 10'h000, lv_code = 10'h000, hv_dac, lv_dac;
  logic cmp_hv = 1'b0, cmp_lv = 1'b0;
  logic ce = 1'b1;
  logic [9:0] snap;
  int frz_bad = 0;
  pbp_ovp_t ovp = '0;
  logic adc_ready, adc_valid, czev, soc, conv, done, trip;
  logic [ADC_W-1:0] adc_res;
  logic [CH_W-1:0] ch;
  pbp_results_t res;
  pbp_gate_t gate;
  logic [6:1] sw;
  int errors = 0, num_checks = 0, per_idx = 0, bursts = 0, seed = 41, b0;
  int cyc, c_soc, c_pp1, c_pp2, c_la1, c_lb1;
  bit bad, ph_bad, started, have_last;
  pbp_note_t q[$], last, cur;
  logic [ADC_W-1:0] adc_q[$], base;

  always #12.5 mclk = ~mclk;

  pbp_boost_pwm DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce), .build_selection(build_sel),
    .average_current_regulation_mode(acm), .operator_duty(op_d), .voltage_loop_duty(vl_d),
    .current_loop_duty(cl_d), .first_leg_turn_on_delay(dta), .second_leg_turn_on_delay(dtb),
    .hv_limit_code(hv_code), .lv_limit_code(lv_code), .cmp_hv_over(cmp_hv), .cmp_lv_over(cmp_lv),
    .ovp_det(ovp), .adc_ready(adc_ready), .adc_result_valid(adc_valid), .adc_result(adc_res),
    .gate_q(gate), .counter_zero_event_q(czev), .conversion_start_trigger_q(soc), .adc_convert_q(conv),
    .adc_channel_q(ch), .adc_results_q(res), .adc_burst_done_q(done), .hv_dac_q(hv_dac),
    .lv_dac_q(lv_dac), .trip_q(trip));

  pbp_far_side_model far (.mclk(mclk), .rst_n(rst_n), .gate_q(gate), .adc_convert_q(conv),
    .adc_channel_q(ch), .sw_on(sw), .adc_ready(adc_ready), .adc_result_valid(adc_valid),
    .adc_result(adc_res));

  task automatic cmp_count(string what, int exp, int got);
    num_checks++;
    if (exp != got) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_count

  task automatic cmp_val(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // Period monitor: whole period counted from one zero pulse to the next
  always @(posedge mclk) begin
    if (rst_n !== 1'b1 || trip !== 1'b0 || ce !== 1'b1) begin
      started = 1'b0;
    end else begin
      if (czev === 1'b1) begin
        if (started) begin
          cmp_count("period cycles", PERIOD_CYC, cyc);
          cmp_count("triggers", 1, c_soc);
          cmp_val("pp phase", 1'b0, ph_bad);
          if (q.size() > 0 && q[0].per == per_idx) begin
            cur = q.pop_front();
            cmp_count("pp first on", cur.pp1, c_pp1);
            cmp_count("pp second on", cur.pp2, c_pp2);
            if (cur.legs) cmp_count("leg a on", cur.la1, c_la1);
            if (cur.legs) cmp_count("leg b on", cur.lb1, c_lb1);
            if (cur.flags) cmp_val("diagonals", 1'b0, bad);
          end
        end
        started = 1'b1;
        per_idx++;
        {cyc, c_soc, c_pp1, c_pp2, c_la1, c_lb1, bad} = '0;
        ph_bad = {gate.push_pull_out_first, gate.push_pull_out_second} !== 2'b10;
      end
      cyc++;
      c_soc += soc;
      c_pp1 += gate.push_pull_out_first;
      c_pp2 += gate.push_pull_out_second;
      c_la1 += gate.leg_a_out_first;
      c_lb1 += gate.leg_b_out_first;
      bad |= (sw[2] === sw[3]) || (sw[1] === sw[4]);
      bad |= (sw[6] === 1'b0 && {sw[2], sw[4]} !== 2'b11) || (sw[5] === 1'b0 && {sw[1], sw[3]} !== 2'b11);
      if (done === 1'b1) begin
        bursts++;
        if (adc_q.size() > 0) begin
          base = adc_q.pop_front();
          for (int k = 0; k < BURST_LEN; k++) cmp_val("adc result", base + 12'(k), res[k]);
        end
      end
    end
  end

  task automatic wait_zero();
    int n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (czev !== 1'b1 && n < 500);
    cmp_val("zero event", 1'b1, czev);
    #1;
  endtask : wait_zero

  // New settings land mid-period and must wait for the next zero
  task automatic apply(logic [1:0] b, logic a, int op, int vl, int cl, int da, int db);
    pbp_note_t nt;
    int d;
    wait_zero();
    nt.per = per_idx + 1;
    repeat (150) @(posedge mclk);
    #2;
    {build_sel, acm, op_d, vl_d, cl_d} = {b, a, 10'(op), 10'(vl), 10'(cl)};
    {dta, dtb} = {8'(da), 8'(db)};
    hv_code = 10'($random(seed));
    lv_code = 10'($random(seed));
    if (have_last) q.push_back(last);
    d = (b == BUILD_CLOSED_LOOP) ? (a ? cl : vl) : op;
    d = d < HALF_TICKS + 1 ? HALF_TICKS + 1 : (d > PERIOD_TICKS - 1 ? PERIOD_TICKS - 1 : d);
    nt.pp1 = 2 * (d / 3) + 1;
    nt.pp2 = 401 - 2 * ((602 - d) / 3);
    nt.la1 = 201 - da;
    nt.lb1 = 199 - db;
    nt.legs = have_last && nt.la1 == last.la1 && nt.lb1 == last.lb1;
    nt.flags = nt.legs && da == 0 && db == 0;
    repeat (2) @(posedge mclk);
    #1;
    cmp_val("hv threshold", hv_code, hv_dac);
    cmp_val("lv threshold", lv_code, lv_dac);
    last = nt;
    have_last = 1'b1;
  endtask : apply

  task automatic trip_run(int s);
    int n = 0;
    int bad_cnt = 0;
    @(posedge mclk);
    #2 rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #2 rst_n = 1'b1;
    repeat (60) @(posedge mclk);
    #2;
    case (s)
      0: ovp.ovp_lv = 1'b1;
      1: ovp.ovp_hv = 1'b1;
      2: cmp_hv = 1'b1;
      default: cmp_lv = 1'b1;
    endcase
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (trip !== 1'b1 && n < 8);
    if (s < 2) cmp_count("ovp trip delay", 1, n);
    else cmp_count("comparator trip delay", 5, n);
    cmp_val("tripped gates", 7'h40, {trip, gate});
    #1;
    {ovp, cmp_hv, cmp_lv} = '0;
    repeat (450) begin
      @(posedge mclk);
      #1;
      bad_cnt += ({trip, gate} !== 7'h40);
    end
    cmp_count("gates held low", 0, bad_cnt);
  endtask : trip_run

  initial begin
    repeat (5) @(posedge mclk);
    #2 rst_n = 1'b1;
    apply(2'h1, 1'b0, 450, 0, 0, 0, 0);
    apply(2'h1, 1'b0, 450, 0, 0, 0, 0);
    // Every build value, both loop choices, random duties in the overlap range
    for (int i = 0; i < 8; i++) begin
      apply(2'(i % 4), 1'(i / 4), 301 + {$random(seed)} % 299, 301 + {$random(seed)} % 299,
        301 + {$random(seed)} % 299, 0, 0);
    end
    apply(2'h1, 1'b0, 0, 0, 0, 0, 0);
    apply(2'h2, 1'b1, 0, 0, 1023, 0, 0);
    apply(2'h2, 1'b0, 0, 1023, 0, 5, 9);
    apply(2'h1, 1'b0, 301, 0, 0, 5, 9);
    apply(2'h1, 1'b0, 599, 0, 0, 0, 0);
    apply(2'h1, 1'b0, 450, 0, 0, 0, 0);
    apply(2'h1, 1'b0, 450, 0, 0, 0, 0);
    b0 = bursts;
    repeat (3) adc_q.push_back(12'hA50);
    repeat (3) wait_zero();
    repeat (100) @(posedge mclk);
    cmp_count("bursts", 3, bursts - b0);
    // Enable low must hold the gate, zero, trigger, convert and trip outputs where they stand; kept clear of zero and bursts
    repeat ({$random(seed)} % 200) @(posedge mclk);
    #2 ce = 1'b0;
    snap = {gate, czev, soc, conv, trip};
    repeat (20 + {$random(seed)} % 20) begin
      @(posedge mclk);
      #1;
      frz_bad += ({gate, czev, soc, conv, trip} !== snap);
    end
    cmp_count("frozen outputs", 0, frz_bad);
    #1 ce = 1'b1;
    for (int s = 0; s < 4; s++) trip_run(s);
    close_out();
  end

  // Run needs about 10000 cycles; this cuts a hang short
  initial begin
    #1_000_000;
    errors++;
    $display("ERROR watchdog expected finish seen timeout");
    close_out();
  end
endmodule : pbp_boost_pwm_tb

// ===== bench/pbp_far_side_model.sv
// Far side: switch gate drivers and the sampling converter
`timescale 1ns/1ps
module pbp_far_side_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire pbp_pkg::pbp_gate_t gate_q,
  input wire logic adc_convert_q,
  input wire logic [pbp_pkg::CH_W-1:0] adc_channel_q,
  output logic [6:1] sw_on,
  output logic adc_ready,
  output logic adc_result_valid,
  output logic [pbp_pkg::ADC_W-1:0] adc_result
);
  import pbp_pkg::*;
  int seed = 41;
  logic [1:0] st_q;
  logic [2:0] wait_q;
  logic [CH_W-1:0] ch_q;
  // Index is the switch number on the power stage
  assign sw_on = {gate_q.push_pull_out_first, gate_q.push_pull_out_second, gate_q.leg_b_out_second,
    gate_q.leg_a_out_second, gate_q.leg_a_out_first, gate_q.leg_b_out_first};
  // Random latency so requests are met both at once and late; data toggles when not valid
  always @(posedge mclk) begin
    adc_ready <= 1'b0;
    adc_result_valid <= 1'b0;
    adc_result <= rst_n ? ~adc_result : 12'h5A5;
    if (!rst_n) begin
      st_q <= 2'h0;
      wait_q <= 3'h0;
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end else begin
      case (st_q)
        2'h0: if (adc_convert_q) begin
          st_q <= 2'h1;
          wait_q <= 3'({$random(seed)} % 4);
        end
        2'h1: begin
          adc_ready <= 1'b1;
          ch_q <= adc_channel_q;
          st_q <= 2'h2;
        end
        2'h2: begin
          st_q <= 2'h3;
          wait_q <= 3'({$random(seed)} % 4);
        end
        default: begin
          adc_result_valid <= 1'b1;
          adc_result <= 12'hA50 + 12'(ch_q);
          st_q <= 2'h0;
        end
      endcase
    end
  end
endmodule : pbp_far_side_model

// ===== rtl/pbp_boost_pwm.sv
// Push-pull boost switching waveform generator with one-shot trip
// Notes on behaviour
// - All waveforms repeat at 100 kHz, a 10 us switching period.
// - A period spans 600 ticks of a 60 MHz time base.
// - Three time-base counters count up then down, symmetric triangles.
// - Each bridge leg's two outputs run at half duty, complementary.
// - Push-pull outputs exceed half duty, shifted half a period, overlapping.
// - Leg A drives switches two/three, leg B one/four, push-pull six/five.
// - With zero turn-on delays, the matching diagonal bridge pair is on when push-pull overlap ends.
// - With zero turn-on delays, while switch six is off, bridge switches two and four are both on.
// - With zero turn-on delays, while switch five is off, bridge switches one and three are both on.
// - Leg A counter reaching zero raises the control interrupt.
// - Leg B zero triggers a burst of five 12-bit conversions each period.
// - Either current comparator over its limit trips all three generators.
// - Each comparator threshold comes from a 10-bit DAC on its inverting input.
// - Low- or high-side overvoltage from supervision also trips all generators.
// - Any trip forces all six outputs low at once.
// - Outputs stay low after a trip until device reset.
// - Build 1 is open-loop drive with sampling; build 2 is closed loop.
// - Open loop uses operator duty; samples are only observed.
// - Per-leg programmable turn-on delays apply to the bridge switches.
`timescale 1ns/1ps
module pbp_boost_pwm (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [1:0] build_selection,
  input wire logic average_current_regulation_mode,
  input wire logic [pbp_pkg::DUTY_W-1:0] operator_duty,
  input wire logic [pbp_pkg::DUTY_W-1:0] voltage_loop_duty,
  input wire logic [pbp_pkg::DUTY_W-1:0] current_loop_duty,
  input wire logic [pbp_pkg::DT_W-1:0] first_leg_turn_on_delay,
  input wire logic [pbp_pkg::DT_W-1:0] second_leg_turn_on_delay,
  input wire logic [pbp_pkg::DAC_W-1:0] hv_limit_code,
  input wire logic [pbp_pkg::DAC_W-1:0] lv_limit_code,
  input wire logic cmp_hv_over,
  input wire logic cmp_lv_over,
  input wire pbp_pkg::pbp_ovp_t ovp_det,
  input wire logic adc_ready,
  input wire logic adc_result_valid,
  input wire logic [pbp_pkg::ADC_W-1:0] adc_result,
  output pbp_pkg::pbp_gate_t gate_q,
  output logic counter_zero_event_q,
  output logic conversion_start_trigger_q,
  output logic adc_convert_q,
  output logic [pbp_pkg::CH_W-1:0] adc_channel_q,
  output pbp_pkg::pbp_results_t adc_results_q,
  output logic adc_burst_done_q,
  output logic [pbp_pkg::DAC_W-1:0] hv_dac_q,
  output logic [pbp_pkg::DAC_W-1:0] lv_dac_q,
  output logic trip_q
);
  import pbp_pkg::*;

  function automatic logic [DUTY_W-1:0] clamp_duty(input logic [DUTY_W-1:0] d);
    if (d < DUTY_MIN) begin
      clamp_duty = DUTY_MIN;
    end else if (d > DUTY_MAX) begin
      clamp_duty = DUTY_MAX;
    end else begin
      clamp_duty = d;
    end
  endfunction : clamp_duty

  logic [NUM_TB-1:0][CNT_W-1:0] cnt_q;
  logic [NUM_TB-1:0] up_q;
  logic [NUM_TB-1:0] zero_w;
  logic [1:0][SYNC_STAGES-1:0] sync_q;
  logic [1:0] cmp_flt_q;
  logic [1:0] cmp_pin;
  logic trip_now;
  logic [DUTY_W-1:0] duty_sel;
  logic [DUTY_W-1:0] duty_sh_q;
  logic [DT_W-1:0] dt_a_sh_q;
  logic [DT_W-1:0] dt_b_sh_q;
  logic [3:0] br_raw;
  logic [3:0] br_on;
  logic [3:0][DT_W-1:0] dt_cnt_q;
  logic pp_first_raw;
  logic pp_second_raw;
  pbp_adc_st_t adc_st_q;

  // Three counters, identically reset so they stay phase aligned
  generate
    for (genvar i = 0; i < NUM_TB; i++) begin : g_tb
      assign zero_w[i] = (cnt_q[i] == CNT_RST);
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          cnt_q[i] <= CNT_RST;
          up_q[i] <= 1'b1;
        end else if (ce) begin
          if (up_q[i]) begin
            cnt_q[i] <= cnt_q[i] + CNT_STEP;
            if (cnt_q[i] + CNT_STEP == CNT_PEAK) begin
              up_q[i] <= 1'b0;
            end
          end else begin
            cnt_q[i] <= cnt_q[i] - CNT_STEP;
            if (cnt_q[i] == CNT_STEP) begin
              up_q[i] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // Comparator pins are asynchronous; accept a level once two late stages agree
  assign cmp_pin = {cmp_lv_over, cmp_hv_over};
  generate
    for (genvar k = 0; k < 2; k++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          sync_q[k] <= '0;
          cmp_flt_q[k] <= 1'b0;
        end else if (ce) begin
          sync_q[k] <= {sync_q[k][SYNC_STAGES-2:0], cmp_pin[k]};
          if (sync_q[k][1] == sync_q[k][2]) begin
            cmp_flt_q[k] <= sync_q[k][2];
          end
        end
      end
    end
  endgenerate

  // Thresholds for the analog comparators' inverting inputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hv_dac_q <= '0;
      lv_dac_q <= '0;
    end else if (ce) begin
      hv_dac_q <= hv_limit_code;
      lv_dac_q <= lv_limit_code;
    end
  end

  assign trip_now = cmp_flt_q[0] | cmp_flt_q[1] | ovp_det.ovp_lv | ovp_det.ovp_hv;

  // Only reset releases the trip; no software path clears it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trip_q <= 1'b0;
    end else if (ce) begin
      trip_q <= trip_q | trip_now;
    end
  end

  // Unknown build values fall back to operator duty, the safer choice
  always_comb begin
    if (build_selection == BUILD_CLOSED_LOOP) begin
      duty_sel = average_current_regulation_mode ? current_loop_duty : voltage_loop_duty;
    end else begin
      duty_sel = operator_duty;
    end
  end

  // Settings shadowed at zero so no period mixes old and new values
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      duty_sh_q <= DUTY_RST;
      dt_a_sh_q <= DT_RST;
      dt_b_sh_q <= DT_RST;
    end else if (ce) begin
      if (zero_w[TB_PP]) begin
        duty_sh_q <= clamp_duty(duty_sel);
      end
      if (zero_w[TB_LEG_A]) begin
        dt_a_sh_q <= first_leg_turn_on_delay;
      end
      if (zero_w[TB_LEG_B]) begin
        dt_b_sh_q <= second_leg_turn_on_delay;
      end
    end
  end

  // Switch six off around the peak, switch five off around zero
  assign pp_first_raw = !(cnt_q[TB_PP] > {1'b0, duty_sh_q});
  assign pp_second_raw = !(cnt_q[TB_PP] < CNT_PEAK - {1'b0, duty_sh_q});
  // Leg A high across the peak, leg B across zero
  assign br_raw[0] = (cnt_q[TB_LEG_A] >= CNT_MID);
  assign br_raw[1] = !br_raw[0];
  assign br_raw[2] = (cnt_q[TB_LEG_B] < CNT_MID);
  assign br_raw[3] = !br_raw[2];

  // Turn-on delay per bridge output, turn-off immediate
  generate
    for (genvar j = 0; j < 4; j++) begin : g_dt
      logic [DT_W-1:0] dt_lim;
      assign dt_lim = (j < 2) ? dt_a_sh_q : dt_b_sh_q;
      assign br_on[j] = br_raw[j] && (dt_cnt_q[j] >= dt_lim);
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          dt_cnt_q[j] <= '0;
        end else if (ce) begin
          if (!br_raw[j]) begin
            dt_cnt_q[j] <= '0;
          end else if (dt_cnt_q[j] < dt_lim) begin
            dt_cnt_q[j] <= dt_cnt_q[j] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // Trip term enters here too, so outputs drop on the same edge it is seen
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gate_q <= '0;
    end else if (ce) begin
      if (trip_q || trip_now) begin
        gate_q <= '0;
      end else begin
        gate_q.leg_a_out_first <= br_on[0];
        gate_q.leg_a_out_second <= br_on[1];
        gate_q.leg_b_out_first <= br_on[2];
        gate_q.leg_b_out_second <= br_on[3];
        gate_q.push_pull_out_first <= pp_first_raw;
        gate_q.push_pull_out_second <= pp_second_raw;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      counter_zero_event_q <= 1'b0;
      conversion_start_trigger_q <= 1'b0;
    end else if (ce) begin
      counter_zero_event_q <= zero_w[TB_LEG_A];
      conversion_start_trigger_q <= zero_w[TB_LEG_B];
    end
  end

  // Burst sequencer; a trigger during a burst is dropped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      adc_st_q <= ADC_IDLE;
      adc_convert_q <= 1'b0;
      adc_channel_q <= '0;
      adc_burst_done_q <= 1'b0;
    end else if (ce) begin
      adc_burst_done_q <= 1'b0;
      case (adc_st_q)
        ADC_IDLE: begin
          if (conversion_start_trigger_q) begin
            adc_st_q <= ADC_REQ;
            adc_convert_q <= 1'b1;
            adc_channel_q <= '0;
          end
        end
        ADC_REQ: begin
          if (adc_ready) begin
            adc_st_q <= ADC_WAIT;
            adc_convert_q <= 1'b0;
          end
        end
        ADC_WAIT: begin
          if (adc_result_valid) begin
            if (adc_channel_q == CH_LAST) begin
              adc_st_q <= ADC_IDLE;
              adc_burst_done_q <= 1'b1;
            end else begin
              adc_st_q <= ADC_REQ;
              adc_convert_q <= 1'b1;
              adc_channel_q <= adc_channel_q + 1'b1;
            end
          end
        end
        default: begin
          adc_st_q <= ADC_IDLE;
          adc_convert_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      adc_results_q <= '0;
    end else if (ce) begin
      if (adc_st_q == ADC_WAIT && adc_result_valid) begin
        adc_results_q[adc_channel_q] <= adc_result;
      end
    end
  end

  // Helper state for the checks below
  logic live_q;
  logic seen_q;
  logic [9:0] per_cnt_q;
  logic [2:0] burst_n_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      live_q <= 1'b0;
      seen_q <= 1'b0;
      per_cnt_q <= '0;
      burst_n_q <= '0;
    end else if (ce) begin
      live_q <= 1'b1;
      per_cnt_q <= counter_zero_event_q ? 10'h000 : per_cnt_q + 10'h001;
      if (counter_zero_event_q) begin
        seen_q <= 1'b1;
      end
      if (adc_st_q == ADC_IDLE) begin
        burst_n_q <= '0;
      end else if (adc_st_q == ADC_WAIT && adc_result_valid) begin
        burst_n_q <= burst_n_q + 3'h1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !ce);

  AST_PERIOD: assert property (counter_zero_event_q && seen_q |-> per_cnt_q == 10'(PERIOD_CYC - 1))
    else $error("switching period is not 400 cycles");
  AST_TB_ALIGN: assert property (cnt_q[0] == cnt_q[1] && cnt_q[1] == cnt_q[2] && cnt_q[0] <= CNT_PEAK)
    else $error("time-base counters out of range or misaligned");
  AST_TB_TURN: assert property (cnt_q[0] == CNT_PEAK |=> cnt_q[0] == CNT_PEAK - CNT_STEP ##1 !up_q[0])
    else $error("counter did not turn at the peak");
  AST_LEG_EXCL: assert property (!(gate_q.leg_a_out_first && gate_q.leg_a_out_second)
    && !(gate_q.leg_b_out_first && gate_q.leg_b_out_second))
    else $error("both outputs of one leg high");
  AST_PP_OVERLAP: assert property (live_q && !trip_q && !$past(trip_now)
    |-> gate_q.push_pull_out_first || gate_q.push_pull_out_second)
    else $error("push-pull outputs both off");
  AST_DIAG_SIX: assert property (live_q && !trip_q && dt_a_sh_q == 8'h00 && dt_b_sh_q == 8'h00
    && $past(dt_a_sh_q) == 8'h00 && $past(dt_b_sh_q) == 8'h00 && !gate_q.push_pull_out_first
    |-> gate_q.leg_a_out_first && gate_q.leg_b_out_second)
    else $error("switches two and four not on while six is off");
  AST_DIAG_FIVE: assert property (live_q && !trip_q && dt_a_sh_q == 8'h00 && dt_b_sh_q == 8'h00
    && $past(dt_a_sh_q) == 8'h00 && $past(dt_b_sh_q) == 8'h00 && !gate_q.push_pull_out_second
    |-> gate_q.leg_b_out_first && gate_q.leg_a_out_second)
    else $error("switches one and three not on while five is off");
  AST_IRQ: assert property ($rose(counter_zero_event_q) |-> $past(cnt_q[0]) == CNT_RST)
    else $error("interrupt not aligned to leg A zero");
  AST_BURST: assert property (adc_burst_done_q |-> $past(burst_n_q) == 3'(BURST_LEN - 1))
    else $error("burst did not hold five conversions");
  AST_TRIP_LOW: assert property (trip_now |=> gate_q == '0 && trip_q)
    else $error("outputs not forced low on trip");
  AST_TRIP_HOLD: assert property (trip_q |=> trip_q && gate_q == '0)
    else $error("trip released before reset");
  AST_CLAMP: assert property (duty_sh_q >= DUTY_MIN && duty_sh_q <= DUTY_MAX)
    else $error("duty outside overlap range");
  AST_SHADOW: assert property ($changed(duty_sh_q) |-> $past(cnt_q[2]) == CNT_RST)
    else $error("duty changed away from counter zero");

  COV_TRIP: cover property (live_q && !trip_q ##1 trip_q);
  COV_BURST: cover property (adc_burst_done_q);
  COV_DUTY: cover property ($changed(duty_sh_q));
  COV_CLOSED: cover property (build_selection == BUILD_CLOSED_LOOP && counter_zero_event_q);

endmodule : pbp_boost_pwm

// ===== rtl/pbp_pkg.sv
// Shared constants and types for the push-pull boost waveform block
package pbp_pkg;

  // Clock and switching timing
  localparam int CLK_NS = 25;
  localparam int SW_PERIOD_NS = 10000;
  localparam int TICK_MHZ = 60;
  localparam int PERIOD_CYC = SW_PERIOD_NS / CLK_NS;
  localparam int PERIOD_TICKS = SW_PERIOD_NS * TICK_MHZ / 1000;
  localparam int HALF_TICKS = PERIOD_TICKS / 2;

  // Counters hold half-ticks so a 60 MHz tick grid maps onto the slower clock
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] CNT_PEAK = CNT_W'(2 * HALF_TICKS);
  localparam logic [CNT_W-1:0] CNT_MID = CNT_W'(HALF_TICKS);
  localparam logic [CNT_W-1:0] CNT_STEP = CNT_W'(2 * PERIOD_TICKS / PERIOD_CYC);
  localparam logic [CNT_W-1:0] CNT_RST = CNT_W'(0);
  localparam int NUM_TB = 3;
  localparam int TB_LEG_A = 0;
  localparam int TB_LEG_B = 1;
  localparam int TB_PP = 2;

  // Push-pull duty in ticks, kept inside the overlap range
  localparam int DUTY_W = 10;
  localparam logic [DUTY_W-1:0] DUTY_MIN = DUTY_W'(HALF_TICKS + 1);
  localparam logic [DUTY_W-1:0] DUTY_MAX = DUTY_W'(PERIOD_TICKS - 1);
  localparam logic [DUTY_W-1:0] DUTY_RST = DUTY_W'(HALF_TICKS + HALF_TICKS / 2);

  localparam int DT_W = 8;
  localparam logic [DT_W-1:0] DT_RST = 8'h00;
  localparam int DAC_W = 10;
  localparam int ADC_W = 12;
  localparam int BURST_LEN = 5;
  localparam int CH_W = 3;
  localparam logic [CH_W-1:0] CH_LAST = CH_W'(BURST_LEN - 1);
  localparam int SYNC_STAGES = 3;

  localparam logic [1:0] BUILD_OPEN_LOOP = 2'h1;
  localparam logic [1:0] BUILD_CLOSED_LOOP = 2'h2;

  typedef enum logic [1:0] {
    ADC_IDLE,
    ADC_REQ,
    ADC_WAIT
  } pbp_adc_st_t;

  typedef struct packed {
    logic leg_a_out_first;
    logic leg_a_out_second;
    logic leg_b_out_first;
    logic leg_b_out_second;
    logic push_pull_out_first;
    logic push_pull_out_second;
  } pbp_gate_t;

  typedef struct packed {
    logic ovp_lv;
    logic ovp_hv;
  } pbp_ovp_t;

  typedef logic [BURST_LEN-1:0][ADC_W-1:0] pbp_results_t;

endpackage : pbp_pkg
